// ### logic/tcco_pkg.sv
`default_nettype none
package tcco_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_TMODE     = 4'h0;
    localparam logic [3:0] ADR_RUN       = 4'h1;
    localparam logic [3:0] ADR_A_LO      = 4'h2;
    localparam logic [3:0] ADR_A_HI      = 4'h3;
    localparam logic [3:0] ADR_B_LO      = 4'h4;
    localparam logic [3:0] ADR_B_HI      = 4'h5;
    localparam logic [3:0] ADR_C_CTL     = 4'h6;
    localparam logic [3:0] ADR_C_MODE    = 4'h7;
    localparam logic [3:0] ADR_C_RLD_LO  = 4'h8;
    localparam logic [3:0] ADR_C_RLD_HI  = 4'h9;
    localparam logic [3:0] ADR_C_LO      = 4'hA;
    localparam logic [3:0] ADR_C_HI      = 4'hB;
    localparam logic [3:0] ADR_IRQ_STS   = 4'hC;
    localparam logic [3:0] ADR_IRQ_MASK  = 4'hD;
    localparam logic [3:0] ADR_CLK_CFG   = 4'hE;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int A_CNT_BIT  = 2;
    localparam int A_GATE_BIT = 3;
    localparam int B_CNT_BIT  = 6;
    localparam int B_GATE_BIT = 7;
    localparam int RUN_A_BIT  = 0;
    localparam int RUN_B_BIT  = 1;
    localparam int C_CP_BIT   = 0;
    localparam int C_CT_BIT   = 1;
    localparam int C_TR_BIT   = 2;
    localparam int C_EXEN_BIT = 3;
    localparam int C_TCLK_BIT = 4;
    localparam int C_RCLK_BIT = 5;
    localparam int C_OE_BIT   = 1;
    localparam int STS_A_BIT  = 0;
    localparam int STS_B_BIT  = 1;
    localparam int STS_C_BIT  = 2;
    localparam int STS_X_BIT  = 3;
    localparam int SIX_BIT    = 0;

    // ------------------------------------------------------------
    // Reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_RST   = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [3:0]  MC_LAST12 = 4'hB;
    localparam logic [3:0]  MC_LAST6  = 4'h5;

    typedef enum logic [1:0] {
        TCCO_M13   = 2'h0,
        TCCO_M16   = 2'h1,
        TCCO_M8AR  = 2'h2,
        TCCO_SPLIT = 2'h3
    } tcco_mode_t;

    typedef struct packed {
        logic        ovf;
        logic [15:0] val;
    } tcco_step_t;

    function automatic tcco_step_t tcco_step(input tcco_mode_t md,
                                             input logic [15:0] v);
        tcco_step_t  r;
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        s13 = {1'b0, v[15:8], v[4:0]} + 14'h0001;
        s16 = {1'b0, v} + 17'h00001;
        s8  = {1'b0, v[7:0]} + 9'h001;
        case (md)
            TCCO_M13: begin
                r.ovf = s13[13];
                r.val = {s13[12:5], v[7:5], s13[4:0]};
            end
            TCCO_M16: begin
                r.ovf = s16[16];
                r.val = s16[15:0];
            end
            TCCO_M8AR: begin
                r.ovf = s8[8];
                r.val = {v[15:8], s8[8] ? v[15:8] : s8[7:0]};
            end
            default: begin
                r.ovf = s8[8];
                r.val = {v[15:8], s8[7:0]};
            end
        endcase
        return r;
    endfunction

endpackage
`default_nettype wire

// ### logic/tcco_timers.sv
// Summary of operation
// - Three 16-bit timers, each reachable as low and high byte registers.
// - First timer nibble picks modes 0-3, counter use and pin gating.
// - Second timer upper nibble likewise; its mode 3 holds the count.
// - Internal control: first timer runs only while its run bit is set; in mode 3 its high byte runs on the second run bit.
// - External control: first timer also needs its gate pin high.
// - External control: second timer also needs its own gate pin high.
// - Third timer auto-reload or capture, as timer or counter.
// - Trigger pin falling edge reloads or captures, except in baud mode.
// - Third timer overflows give receive and transmit baud ticks.
// - Clock output drives a square wave when counter-select clear.
// - Output toggles per overflow at oscillator over n times span.
// - Reload value is reload high byte above reload low byte.
// - Baud or clock-output overflows raise no interrupt flag.
// - Baud generation and clock output may run together.
// - Clock-output pin also serves as third timer count input.
// - Mode register bit enables the clock-output pin driver.
// - Machine cycle is 12 clocks, or 6 with clock doubling.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tcco_timers
    import tcco_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer_a_gate_pin,
    input  wire logic       timer_b_gate_pin,
    input  wire logic       timer_a_count_pin,
    input  wire logic       timer_b_count_pin,
    input  wire logic       timer_c_trigger_pin,
    input  wire logic       clkout_pin_in,
    output logic            clkout_pin_out,
    output logic            clkout_pin_oe,
    output logic            baud_rx_tick,
    output logic            baud_tx_tick,
    output logic            irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  timer_mode_select_reg;
    logic [1:0]  run_r;
    logic [5:0]  third_timer_control_reg;
    logic        third_timer_mode_reg;
    logic        six_clk_r;
    logic [15:0] ta_r;
    logic [15:0] tb_r;
    logic [15:0] tc_r;
    logic [15:0] rld_r;
    logic [3:0]  sts_r;
    logic [3:0]  mask_r;
    logic [3:0]  mc_r;
    logic        a_cnt_prev_r;
    logic        b_cnt_prev_r;
    logic        c_cnt_prev_r;
    logic        trig_prev_r;
    logic        clk_out_r;
    logic        rx_tick_r;
    logic        tx_tick_r;
    logic [7:0]  rdata_r;

    logic timer_a_run;
    logic timer_b_run;
    logic timer_c_run;
    logic timer_c_counter_select;
    logic timer_c_output_enable;
    logic [7:0] timer_c_reload_high;
    logic [7:0] timer_c_reload_low;

    assign timer_a_run            = run_r[RUN_A_BIT];
    assign timer_b_run            = run_r[RUN_B_BIT];
    assign timer_c_run            = third_timer_control_reg[C_TR_BIT];
    assign timer_c_counter_select = third_timer_control_reg[C_CT_BIT];
    assign timer_c_output_enable  = third_timer_mode_reg;
    assign timer_c_reload_high    = rld_r[15:8];
    assign timer_c_reload_low     = rld_r[7:0];

    logic wr_tmode;
    logic wr_a_lo;
    logic wr_a_hi;
    logic wr_b_lo;
    logic wr_b_hi;
    logic wr_c_lo;
    logic wr_c_hi;

    assign wr_tmode = reg_wr && reg_addr == ADR_TMODE;
    assign wr_a_lo  = reg_wr && reg_addr == ADR_A_LO;
    assign wr_a_hi  = reg_wr && reg_addr == ADR_A_HI;
    assign wr_b_lo  = reg_wr && reg_addr == ADR_B_LO;
    assign wr_b_hi  = reg_wr && reg_addr == ADR_B_HI;
    assign wr_c_lo  = reg_wr && reg_addr == ADR_C_LO;
    assign wr_c_hi  = reg_wr && reg_addr == ADR_C_HI;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_mode_select_reg   <= REG_RST;
            run_r                   <= 2'h0;
            third_timer_control_reg <= 6'h00;
            third_timer_mode_reg    <= 1'b0;
            six_clk_r               <= 1'b0;
            mask_r                  <= 4'h0;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                ADR_TMODE:    timer_mode_select_reg <= reg_wdata;
                ADR_RUN:      run_r <= reg_wdata[1:0];
                ADR_C_CTL:    third_timer_control_reg <= reg_wdata[5:0];
                ADR_C_MODE:   third_timer_mode_reg <= reg_wdata[C_OE_BIT];
                ADR_CLK_CFG:  six_clk_r <= reg_wdata[SIX_BIT];
                ADR_IRQ_MASK: mask_r <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Machine cycle and pin edges
    // ------------------------------------------------------------
    logic mc_tick;
    logic fast_tick;

    // A fresh doubling setting takes effect at once; a count already past 5 runs on to 15 and wraps first.
    assign mc_tick   = mc_r == (six_clk_r ? MC_LAST6 : MC_LAST12);
    assign fast_tick = six_clk_r | mc_r[0];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mc_r <= 4'h0;
        end else if (clk_en) begin
            mc_r <= mc_tick ? 4'h0 : mc_r + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            a_cnt_prev_r <= 1'b0;
            b_cnt_prev_r <= 1'b0;
            c_cnt_prev_r <= 1'b0;
            trig_prev_r  <= 1'b0;
        end else if (clk_en) begin
            a_cnt_prev_r <= timer_a_count_pin;
            b_cnt_prev_r <= timer_b_count_pin;
            c_cnt_prev_r <= clkout_pin_in;
            trig_prev_r  <= timer_c_trigger_pin;
        end
    end

    logic a_fall;
    logic b_fall;
    logic c_fall;
    logic trig_fall;

    assign a_fall    = a_cnt_prev_r & ~timer_a_count_pin;
    assign b_fall    = b_cnt_prev_r & ~timer_b_count_pin;
    assign c_fall    = c_cnt_prev_r & ~clkout_pin_in;
    assign trig_fall = trig_prev_r & ~timer_c_trigger_pin;

    // ------------------------------------------------------------
    // First and second timers
    // ------------------------------------------------------------
    tcco_mode_t a_mode;
    tcco_mode_t b_mode;
    logic       a_split;
    logic       ta_en;
    logic       th_en;
    logic       tb_en;
    tcco_step_t sa;
    tcco_step_t sb;

    assign a_mode  = tcco_mode_t'(timer_mode_select_reg[1:0]);
    assign b_mode  = tcco_mode_t'(timer_mode_select_reg[5:4]);
    assign a_split = a_mode == TCCO_SPLIT;
    assign sa      = tcco_step(a_mode, ta_r);
    assign sb      = tcco_step(b_mode, tb_r);

    assign ta_en = timer_a_run
        & (~timer_mode_select_reg[A_GATE_BIT] | timer_a_gate_pin)
        & (timer_mode_select_reg[A_CNT_BIT] ? a_fall : mc_tick);
    // In split mode the high byte borrows the second run bit.
    assign th_en = a_split & timer_b_run & mc_tick;
    assign tb_en = timer_b_run & (b_mode != TCCO_SPLIT)
        & (~timer_mode_select_reg[B_GATE_BIT] | timer_b_gate_pin)
        & (timer_mode_select_reg[B_CNT_BIT] ? b_fall : mc_tick);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ta_r <= CNT_RST;
        end else if (clk_en) begin
            if (wr_a_lo) begin
                ta_r[7:0] <= reg_wdata;
            end else if (ta_en) begin
                ta_r[7:0] <= sa.val[7:0];
            end
            if (wr_a_hi) begin
                ta_r[15:8] <= reg_wdata;
            end else if (th_en) begin
                ta_r[15:8] <= ta_r[15:8] + 8'h01;
            end else if (ta_en && !a_split) begin
                ta_r[15:8] <= sa.val[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tb_r <= CNT_RST;
        end else if (clk_en) begin
            if (wr_b_lo) begin
                tb_r[7:0] <= reg_wdata;
            end else if (tb_en) begin
                tb_r[7:0] <= sb.val[7:0];
            end
            if (wr_b_hi) begin
                tb_r[15:8] <= reg_wdata;
            end else if (tb_en) begin
                tb_r[15:8] <= sb.val[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Third timer
    // ------------------------------------------------------------
    logic baud;
    logic clkout_mode;
    logic c_en;
    logic c_ovf;
    logic c_reload_ovf;
    logic ext_ev;
    logic ext_act;
    logic cp;

    assign cp          = third_timer_control_reg[C_CP_BIT];
    assign baud        = third_timer_control_reg[C_RCLK_BIT]
                       | third_timer_control_reg[C_TCLK_BIT];
    assign clkout_mode = timer_c_output_enable
                       & ~timer_c_counter_select;
    // Baud and clock output both use the fast prescale.
    assign c_en = timer_c_run & (timer_c_counter_select ? c_fall
                : ((baud | clkout_mode) ? fast_tick : mc_tick));
    assign c_ovf        = c_en && tc_r == 16'hFFFF;
    assign c_reload_ovf = c_ovf & (baud | clkout_mode | ~cp);
    assign ext_ev  = third_timer_control_reg[C_EXEN_BIT] & trig_fall;
    assign ext_act = ext_ev & ~baud;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tc_r <= CNT_RST;
        end else if (clk_en) begin
            if (wr_c_lo || wr_c_hi) begin
                if (wr_c_lo) begin
                    tc_r[7:0] <= reg_wdata;
                end
                if (wr_c_hi) begin
                    tc_r[15:8] <= reg_wdata;
                end
            end else if (c_reload_ovf || (ext_act && !cp)) begin
                tc_r <= {timer_c_reload_high, timer_c_reload_low};
            end else if (c_en) begin
                tc_r <= tc_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rld_r <= CNT_RST;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == ADR_C_RLD_LO) begin
                rld_r[7:0] <= reg_wdata;
            end else if (reg_wr && reg_addr == ADR_C_RLD_HI) begin
                rld_r[15:8] <= reg_wdata;
            end else if (ext_act && cp) begin
                rld_r <= tc_r;
            end
        end
    end

    // Two overflows per output period give the n factor of 2 or 4.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_out_r <= 1'b0;
        end else if (clk_en && c_ovf && clkout_mode) begin
            clk_out_r <= ~clk_out_r;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_tick_r <= 1'b0;
            tx_tick_r <= 1'b0;
        end else if (clk_en) begin
            rx_tick_r <= c_ovf & third_timer_control_reg[C_RCLK_BIT];
            tx_tick_r <= c_ovf & third_timer_control_reg[C_TCLK_BIT];
        end
    end

    assign clkout_pin_out = clk_out_r;
    assign clkout_pin_oe  = clkout_mode;
    assign baud_rx_tick   = rx_tick_r;
    assign baud_tx_tick   = tx_tick_r;

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    logic [3:0] sts_set;

    assign sts_set[STS_A_BIT] = ta_en & sa.ovf;
    assign sts_set[STS_B_BIT] = a_split ? (th_en && ta_r[15:8] == 8'hFF)
                              : (tb_en & sb.ovf);
    assign sts_set[STS_C_BIT] = c_ovf & ~baud & ~clkout_mode;
    assign sts_set[STS_X_BIT] = ext_ev;

    // A flag raised in the same cycle as its clear survives.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sts_r <= 4'h0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == ADR_IRQ_STS) begin
                sts_r <= (sts_r & ~reg_wdata[3:0]) | sts_set;
            end else begin
                sts_r <= sts_r | sts_set;
            end
        end
    end

    assign irq = |(sts_r & mask_r);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= REG_RST;
        end else if (clk_en) begin
            if (reg_rd) begin
                case (reg_addr)
                    ADR_TMODE:    rdata_r <= timer_mode_select_reg;
                    ADR_RUN:      rdata_r <= {6'h00, run_r};
                    ADR_A_LO:     rdata_r <= ta_r[7:0];
                    ADR_A_HI:     rdata_r <= ta_r[15:8];
                    ADR_B_LO:     rdata_r <= tb_r[7:0];
                    ADR_B_HI:     rdata_r <= tb_r[15:8];
                    ADR_C_CTL:    rdata_r <= {sts_r[STS_C_BIT],
                                      sts_r[STS_X_BIT],
                                      third_timer_control_reg};
                    ADR_C_MODE:   rdata_r <= {6'h00, third_timer_mode_reg,
                                      1'b0};
                    ADR_C_RLD_LO: rdata_r <= timer_c_reload_low;
                    ADR_C_RLD_HI: rdata_r <= timer_c_reload_high;
                    ADR_C_LO:     rdata_r <= tc_r[7:0];
                    ADR_C_HI:     rdata_r <= tc_r[15:8];
                    ADR_IRQ_STS:  rdata_r <= {4'h0, sts_r};
                    ADR_IRQ_MASK: rdata_r <= {4'h0, mask_r};
                    ADR_CLK_CFG:  rdata_r <= {7'h00, six_clk_r};
                    default:      rdata_r <= 8'h00;
                endcase
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_A_HALT: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && !timer_a_run && !reg_wr |=> $stable(ta_r[7:0])
        && (a_split || $stable(ta_r[15:8])))
        else $error("First timer moved while its run bit was clear.");

    AST_A_GATE: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && timer_mode_select_reg[A_GATE_BIT] && !timer_a_gate_pin
        && !reg_wr |=> $stable(ta_r[7:0]))
        else $error("First timer counted with its gate pin low.");

    AST_B_MODE3: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && b_mode == TCCO_SPLIT && !reg_wr |=> $stable(tb_r))
        else $error("Second timer counted in its halted mode.");

    AST_CLKOUT_TOGGLE: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        $changed(clk_out_r) |-> $past(c_ovf && clkout_mode && clk_en))
        else $error("Clock output toggled without an overflow.");

    AST_NO_C_FLAG: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && c_ovf && (baud || clkout_mode)
        && !(ext_ev) |=> !$rose(sts_r[STS_C_BIT]))
        else $error("Overflow flag set in baud or clock-output use.");

    AST_C_RELOAD: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && c_ovf && !cp && !reg_wr |=> tc_r == $past(rld_r))
        else $error("Third timer missed its reload on overflow.");

    AST_TRIG_CAPTURE: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && ext_act && cp && !reg_wr |=> rld_r == $past(tc_r))
        else $error("Trigger edge did not capture the count.");

    AST_BAUD_TICK: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && c_ovf && third_timer_control_reg[C_RCLK_BIT]
        |=> baud_rx_tick ##1 (!$past(clk_en) || !baud_rx_tick
        || $past(c_ovf && third_timer_control_reg[C_RCLK_BIT])))
        else $error("Receive baud tick missing or stretched.");

    AST_C_COUNT: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && timer_c_run && timer_c_counter_select && c_fall
        && !c_ovf && !ext_act && !reg_wr |=> tc_r == $past(tc_r) + 16'h0001)
        else $error("Third timer missed a count edge.");

endmodule
`default_nettype wire

// ### test/tcco_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Far-side pins: count pulses and the shared clock-out pin
// ------------------------------------------------------------
module tcco_pins_model (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic [2:0] pulse_req,
    input  wire logic       drv_out,
    input  wire logic       drv_oe,
    output logic      [2:0] pins,
    output logic            shared_pin
);
    logic [1:0] low_r [3];
    // Lines idle high through pull-ups; a pulse holds a line low two cycles.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        for (int i = 0; i < 3; i++) begin
            if (!arst_n) begin
                low_r[i] <= 2'h0;
            end else if (pulse_req[i]) begin
                low_r[i] <= 2'h2;
            end else if (low_r[i] != 2'h0) begin
                low_r[i] <= low_r[i] - 2'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pins[i] = (low_r[i] == 2'h0);
        end
    end
    // The released shared pin follows the trigger line's pulses.
    assign shared_pin = drv_oe ? drv_out : pins[2];
endmodule
`default_nettype wire

// ### test/tcco_timers_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcco_timers_tb
    import tcco_pkg::*;
();
    logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic ga = 1'b0, gb = 1'b0, ce = 1'b1, shp, cko, coe, rxt, txt, irq;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rv;
    logic [2:0] preq = 3'h0, pins;
    int n_fail = 0, num_checks = 0, hi, p, nr, nt, k;
    logic [19:0] rows [12] = '{20'h05A5A, 20'h23434, 20'h31212, 20'h47878,
        20'h55656, 20'h8CDCD, 20'h9ABAB, 20'hAFEFE, 20'hBFFFF, 20'hD0505,
        20'hF5A00, 20'h00000};
    always #20 sys_clk = ~sys_clk;
    tcco_timers dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_a_gate_pin(ga),
        .timer_b_gate_pin(gb), .timer_a_count_pin(pins[0]),
        .timer_b_count_pin(pins[1]), .timer_c_trigger_pin(pins[2]),
        .clkout_pin_in(shp), .clkout_pin_out(cko), .clkout_pin_oe(coe),
        .baud_rx_tick(rxt), .baud_tx_tick(txt), .irq(irq));
    tcco_pins_model pm_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .pulse_req(preq), .drv_out(cko), .drv_oe(coe), .pins(pins),
        .shared_pin(shp));
    // ------------------------------------------------------------
    // Bus, check and timing tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        chk($sformatf("reg %h", a), e, rv);
    endtask
    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            preq <= m;
            @(posedge sys_clk);
            preq <= 3'h0;
            cyc(4);
        end
    endtask
    // Period and high time between two rises; a missing rise ends the run.
    task automatic per();
        int r;
        logic pv;
        r = 0;
        hi = 0;
        p = 0;
        pv = 1'b1;
        for (int i = 0; i < 200 && r < 2; i++) begin
            @(posedge sys_clk);
            #1;
            if (cko === 1'b1 && pv === 1'b0) r++;
            if (r == 1) p++;
            if (r == 1 && cko === 1'b1) hi++;
            pv = cko;
        end
        if (r < 2) begin
            n_fail++;
            results();
        end
    endtask
    task automatic ticks();
        nr = 0;
        nt = 0;
        repeat (40) begin
            @(posedge sys_clk);
            #1;
            nr += (rxt === 1'b1);
            nt += (txt === 1'b1);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        results();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(16);
        arst_n <= 1'b1;
        chk("irq oe", 8'h00, {6'h00, irq, coe});
        for (int a = 0; a < 16; a++) rc(a[3:0], REG_RST);
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rc(rows[i][19:16], rows[i][7:0]);
        end
        wr(ADR_A_LO, 8'hFE);
        wr(ADR_A_HI, 8'hFF);
        wr(ADR_TMODE, 8'h01);
        wr(ADR_IRQ_MASK, 8'h01);
        wr(ADR_RUN, 8'h01);
        for (k = 0; k < 40; k++) begin
            @(posedge sys_clk);
            #1;
            if (irq === 1'b1) break;
        end
        chk("ovf time", 8'h01, {7'h00, k >= 11 && k <= 25});
        wr(ADR_RUN, 8'h00);
        wr(ADR_IRQ_MASK, 8'h00);
        chk("masked irq", 8'h00, {7'h00, irq});
        rc(ADR_IRQ_STS, 8'h01);
        wr(ADR_IRQ_STS, 8'h01);
        rc(ADR_IRQ_STS, 8'h00);
        wr(ADR_A_LO, 8'h00);
        wr(ADR_TMODE, 8'h09);
        wr(ADR_RUN, 8'h01);
        cyc(40);
        rc(ADR_A_LO, 8'h00);
        // A gate window of 24 clocks always spans two machine cycles.
        ga <= 1'b1;
        cyc(24);
        ga <= 1'b0;
        rc(ADR_A_LO, 8'h02);
        wr(ADR_RUN, 8'h00);
        wr(ADR_TMODE, 8'h01);
        cyc(30);
        rc(ADR_A_LO, 8'h02);
        wr(ADR_TMODE, 8'h55);
        wr(ADR_A_LO, 8'h00);
        wr(ADR_B_LO, 8'h00);
        wr(ADR_RUN, 8'h03);
        pulse(3'h3, 5);
        ce <= 1'b0;
        pulse(3'h3, 1);
        ce <= 1'b1;
        rc(ADR_A_LO, 8'h05);
        rc(ADR_B_LO, 8'h05);
        wr(ADR_A_HI, 8'h80);
        wr(ADR_A_LO, 8'hFF);
        wr(ADR_TMODE, 8'h56);
        pulse(3'h1, 1);
        rc(ADR_A_LO, 8'h80);
        wr(ADR_IRQ_STS, 8'h01);
        wr(ADR_TMODE, 8'h90);
        wr(ADR_RUN, 8'h02);
        cyc(30);
        rc(ADR_B_LO, 8'h05);
        gb <= 1'b1;
        cyc(24);
        gb <= 1'b0;
        rc(ADR_B_LO, 8'h07);
        wr(ADR_TMODE, 8'h30);
        cyc(30);
        rc(ADR_B_LO, 8'h07);
        wr(ADR_RUN, 8'h00);
        wr(ADR_CLK_CFG, 8'h01);
        wr(ADR_C_RLD_LO, 8'hFE);
        wr(ADR_C_RLD_HI, 8'hFF);
        wr(ADR_C_MODE, 8'h02);
        wr(ADR_C_CTL, 8'h04);
        chk("oe", 8'h01, {7'h00, coe});
        per();
        chk("period 6clk", 8'h04, p[7:0]);
        chk("high 6clk", 8'h02, hi[7:0]);
        wr(ADR_CLK_CFG, 8'h00);
        per();
        chk("period 12clk", 8'h08, p[7:0]);
        wr(ADR_CLK_CFG, 8'h01);
        wr(ADR_C_CTL, 8'h34);
        ticks();
        chk("rx", 8'd20, nr[7:0]);
        chk("tx", 8'd20, nt[7:0]);
        chk("oe baud", 8'h01, {7'h00, coe});
        wr(ADR_C_CTL, 8'h14);
        ticks();
        chk("rx off", 8'd0, nr[7:0]);
        chk("tx on", 8'd20, nt[7:0]);
        rc(ADR_IRQ_STS, 8'h00);
        wr(ADR_C_MODE, 8'h00);
        chk("oe off", 8'h00, {7'h00, coe});
        wr(ADR_CLK_CFG, 8'h00);
        wr(ADR_C_CTL, 8'h00);
        wr(ADR_C_RLD_HI, 8'h12);
        wr(ADR_C_HI, 8'h00);
        wr(ADR_C_LO, 8'h00);
        wr(ADR_C_CTL, 8'h04);
        pulse(3'h4, 1);
        rc(ADR_C_HI, 8'h00);
        wr(ADR_C_CTL, 8'h0C);
        pulse(3'h4, 1);
        rc(ADR_C_HI, 8'h12);
        rc(ADR_IRQ_STS, 8'h08);
        wr(ADR_C_CTL, 8'h09);
        wr(ADR_C_HI, 8'h34);
        pulse(3'h4, 1);
        rc(ADR_C_RLD_HI, 8'h34);
        wr(ADR_C_LO, 8'h00);
        wr(ADR_C_CTL, 8'h06);
        pulse(3'h4, 3);
        rc(ADR_C_LO, 8'h03);
        results();
    end
endmodule
`default_nettype wire
